// >>> rtl/ctg_pkg.sv
package ctg_pkg;
   // ****************************************
   // register map, read side
   // ****************************************
   localparam logic [3:0] RD_IN_CHANGE = 4'h4;
   localparam logic [3:0] RD_INT_STATUS = 4'h5;
   localparam logic [3:0] RD_COUNT_UPPER = 4'h6;
   localparam logic [3:0] RD_COUNT_LOWER = 4'h7;
   localparam logic [3:0] RD_IN_PINS = 4'hD;
   localparam logic [3:0] RD_START_CMD = 4'hE;
   localparam logic [3:0] RD_STOP_CMD = 4'hF;
   // ****************************************
   // register map, write side
   // ****************************************
   localparam logic [3:0] WR_CLK_SEL_A = 4'h1;
   localparam logic [3:0] WR_CMD_A = 4'h2;
   localparam logic [3:0] WR_AUX_CTRL = 4'h4;
   localparam logic [3:0] WR_INT_MASK = 4'h5;
   localparam logic [3:0] WR_DIV_UPPER = 4'h6;
   localparam logic [3:0] WR_DIV_LOWER = 4'h7;
   localparam logic [3:0] WR_CLK_SEL_B = 4'h9;
   localparam logic [3:0] WR_CMD_B = 4'hA;
   localparam logic [3:0] WR_OUT_CFG = 4'hD;
   localparam logic [3:0] WR_OUT_SET = 4'hE;
   localparam logic [3:0] WR_OUT_CLR = 4'hF;
   // ****************************************
   // fields and codes
   // ****************************************
   localparam logic [3:0] CMD_TMO_ON = 4'hA;
   localparam logic [3:0] CMD_TMO_OFF = 4'hC;
   localparam logic [3:0] CSR_SEL_CT = 4'hD;
   localparam int ACR_TIMER_BIT = 6;
   localparam int ACR_PRESCALE_BIT = 4;
   localparam int ISR_CT_READY_BIT = 3;
   localparam int ISR_IN_CHANGE_BIT = 7;
   localparam logic [15:0] CT_ROLL_VALUE = 16'hFF55;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_DIVISOR = 16'h0000;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ = 200000000;
   localparam int SAMPLE_HZ = 38400;
   localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
   localparam int CT_PRESCALE = 16;
   typedef enum logic [1:0] {CT_IDLE, CT_RUN, CT_RELOAD, CT_RESTART} ctg_ct_state_t;
endpackage

// >>> rtl/ctg_chg_det.sv
module ctg_chg_det
   import ctg_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic reset, // async reset, high
   input wire logic sample_tick, // one-cycle sampling enable
   input wire logic [3:0] pins, // raw input levels
   output logic [3:0] level, // qualified levels
   output logic [3:0] change // one-cycle pulse per qualified edge
);
   logic [3:0] last_sample_ff;

   // ****************************************
   // two successive samples at the new level
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         last_sample_ff <= 4'hF;
         level <= 4'hF;
         change <= 4'h0;
      end else begin
         change <= 4'h0;
         if (sample_tick) begin
            last_sample_ff <= pins;
            for (int i = 0; i < 4; i++) begin
               if (pins[i] == last_sample_ff[i] && pins[i] != level[i]) begin
                  level[i] <= pins[i];
                  change[i] <= 1'b1;
               end
            end
         end
      end
   end

   property p_two_samples;
      @(posedge clk) disable iff (reset)
      |change |-> $past(sample_tick) && ($past(pins) & change) == (level & change)
         && ($past(last_sample_ff) & change) == (level & change);
   endproperty
   a_two_samples: assert property (p_two_samples) else $error("unqualified change");

   // level may only move on a sampling tick, never between them
   property p_level_on_tick;
      @(posedge clk) disable iff (reset)
      !sample_tick |=> $stable(level);
   endproperty
   a_level_on_tick: assert property (p_level_on_tick) else $error("level moved off tick");
endmodule

// >>> rtl/ctg_top.sv
module ctg_top
   import ctg_pkg::*;
#(
   parameter int SAMPLE_CYCLES = SAMPLE_CYC
)
(
   input wire logic clk, // system clock, 200 MHz
   input wire logic reset, // async reset, high
   input wire logic [3:0] addr, // register address
   input wire logic [7:0] wdata, // write data
   input wire logic wr_stb, // one-cycle write strobe
   input wire logic rd_stb, // one-cycle read strobe
   output logic [7:0] rdata, // read data, valid cycle after rd_stb
   input wire logic alt_bus_mode, // 1: input 6 serves as bus acknowledge
   input wire logic [6:0] in_pins, // general inputs
   input wire logic ext_ct_tick, // external counter clock enable
   input wire logic rx_load_a, // channel a character into its fifo
   input wire logic rx_load_b, // channel b character into its fifo
   input wire logic [7:0] isr_other, // other interrupt sources
   input wire logic [1:0] op01_src, // channel-driven values for outputs 0,1
   input wire logic [7:2] op_alt_src, // alternate sources for outputs 2 and 4..7; bit 3 is unused, since output 3 takes ct_out when selected
   output logic [7:0] out_pins, // general outputs
   output logic ct_out, // counter-timer output
   output logic [7:0] clk_sel_a, // channel a clock selection
   output logic [7:0] clk_sel_b, // channel b clock selection
   output logic [3:0] x16_mode, // rx a, tx a, rx b, tx b oversampling
   output logic intr_n // interrupt, active low
);
   // ****************************************
   // register file
   // ****************************************
   logic [7:0] acr_ff, imr_ff, output_source_config_ff, latch_ff, div_hi_ff, div_lo_ff;
   logic [7:0] csr_a_ff, csr_b_ff;
   logic [3:0] in_delta_ff;
   logic tmo_a_ff, tmo_b_ff, ready_ff, ct_out_ff, done_ff;
   logic [15:0] cnt_ff;
   ctg_ct_state_t state_ff;
   logic [12:0] sample_div_ff;
   logic [3:0] pre_div_ff;
   logic sample_tick, pre_tick, ct_tick;
   logic [3:0] chg_level, chg_pulse;

   logic wr_any, rd_ips, rd_start, rd_stop, tmo_on, timer_mode, rx_hit, expire;
   logic cmd_a_on, cmd_b_on;
   logic [7:0] isr_val;

   function automatic logic is_wr(input logic [3:0] a, input logic [3:0] off);
      return wr_stb && a == off;
   endfunction

   function automatic logic is_rd(input logic [3:0] a, input logic [3:0] off);
      return rd_stb && a == off;
   endfunction

   assign wr_any = wr_stb;
   assign rd_ips = is_rd(addr, RD_IN_CHANGE);
   assign rd_start = is_rd(addr, RD_START_CMD);
   assign rd_stop = is_rd(addr, RD_STOP_CMD);
   assign cmd_a_on = is_wr(addr, WR_CMD_A) && wdata[7:4] == CMD_TMO_ON;
   assign cmd_b_on = is_wr(addr, WR_CMD_B) && wdata[7:4] == CMD_TMO_ON;
   assign tmo_on = tmo_a_ff || tmo_b_ff;
   assign timer_mode = acr_ff[ACR_TIMER_BIT] && !tmo_on;
   assign rx_hit = (rx_load_a && tmo_a_ff) || (rx_load_b && tmo_b_ff);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         acr_ff <= RESET_BYTE;
         imr_ff <= RESET_BYTE;
         output_source_config_ff <= RESET_BYTE;
         div_hi_ff <= RESET_BYTE;
         div_lo_ff <= RESET_BYTE;
         csr_a_ff <= RESET_BYTE;
         csr_b_ff <= RESET_BYTE;
      end else if (wr_any) begin
         unique case (addr)
            WR_AUX_CTRL: acr_ff <= wdata;
            WR_INT_MASK: imr_ff <= wdata;
            WR_OUT_CFG: output_source_config_ff <= wdata;
            WR_DIV_UPPER: div_hi_ff <= wdata;
            WR_DIV_LOWER: div_lo_ff <= wdata;
            WR_CLK_SEL_A: csr_a_ff <= wdata;
            WR_CLK_SEL_B: csr_b_ff <= wdata;
            default: ;
         endcase
      end
   end

   // ****************************************
   // output latch
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         latch_ff <= RESET_BYTE;
      end else if (is_wr(addr, WR_OUT_SET)) begin
         latch_ff <= latch_ff | wdata;
      end else if (is_wr(addr, WR_OUT_CLR)) begin
         latch_ff <= latch_ff & ~wdata;
      end
   end

   always_comb begin
      out_pins[1:0] = op01_src;
      for (int k = 2; k < 8; k++) begin
         out_pins[k] = output_source_config_ff[k] ? op_alt_src[k] : ~latch_ff[k];
      end
      if (output_source_config_ff[3]) begin
         out_pins[3] = ct_out_ff;
      end
   end

   // ****************************************
   // time-out enables per channel
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tmo_a_ff <= 1'b0;
         tmo_b_ff <= 1'b0;
      end else begin
         if (cmd_a_on) begin
            tmo_a_ff <= 1'b1;
         end else if (is_wr(addr, WR_CMD_A) && wdata[7:4] == CMD_TMO_OFF) begin
            tmo_a_ff <= 1'b0;
         end
         if (cmd_b_on) begin
            tmo_b_ff <= 1'b1;
         end else if (is_wr(addr, WR_CMD_B) && wdata[7:4] == CMD_TMO_OFF) begin
            tmo_b_ff <= 1'b0;
         end
      end
   end

   // ****************************************
   // clock enables
   // ****************************************
   // 38.4 kHz tap, a period of about 26 us
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sample_div_ff <= 13'h0000;
      end else if (sample_div_ff == 13'(SAMPLE_CYCLES - 1)) begin
         sample_div_ff <= 13'h0000;
      end else begin
         sample_div_ff <= sample_div_ff + 13'h0001;
      end
   end
   assign sample_tick = sample_div_ff == 13'(SAMPLE_CYCLES - 1);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pre_div_ff <= 4'h0;
      end else begin
         pre_div_ff <= pre_div_ff + 4'h1;
      end
   end
   assign pre_tick = pre_div_ff == 4'(CT_PRESCALE - 1);
   assign ct_tick = acr_ff[ACR_PRESCALE_BIT] ? pre_tick : ext_ct_tick;

   // ****************************************
   // counter-timer
   // ****************************************
   assign expire = ct_tick && state_ff == CT_RUN && cnt_ff == 16'h0000;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff <= CT_IDLE;
         cnt_ff <= RESET_DIVISOR;
         ct_out_ff <= 1'b1;
         done_ff <= 1'b0;
      end else if (cmd_a_on || cmd_b_on) begin
         state_ff <= CT_IDLE;
      end else if (tmo_on) begin
         if (rx_hit && state_ff != CT_RESTART) begin
            state_ff <= CT_RELOAD;
         end else if (ct_tick) begin
            unique case (state_ff)
               CT_RELOAD: begin
                  cnt_ff <= {div_hi_ff, div_lo_ff};
                  state_ff <= CT_RESTART;
               end
               CT_RESTART: state_ff <= CT_RUN;
               CT_RUN: begin
                  if (cnt_ff == 16'h0000) begin
                     state_ff <= CT_IDLE;
                  end else begin
                     cnt_ff <= cnt_ff - 16'h0001;
                  end
               end
               CT_IDLE: ;
            endcase
         end
      end else if (rd_start) begin
         cnt_ff <= {div_hi_ff, div_lo_ff};
         state_ff <= CT_RUN;
         ct_out_ff <= 1'b1;
         done_ff <= 1'b0;
      end else if (rd_stop && !timer_mode) begin
         state_ff <= CT_IDLE;
      end else if (ct_tick && state_ff == CT_RUN) begin
         if (timer_mode) begin
            // half period equals the divisor
            if (cnt_ff <= 16'h0001) begin
               cnt_ff <= {div_hi_ff, div_lo_ff};
               ct_out_ff <= !ct_out_ff;
            end else begin
               cnt_ff <= cnt_ff - 16'h0001;
            end
         end else if (cnt_ff == 16'h0000) begin
            cnt_ff <= CT_ROLL_VALUE;
            ct_out_ff <= 1'b0;
            done_ff <= 1'b1;
         end else begin
            cnt_ff <= cnt_ff - 16'h0001;
         end
      end
   end
   assign ct_out = ct_out_ff;

   // ****************************************
   // ready flag: set beats the stop-read clear in timer mode only (counter-mode stop read preempts the set); rx_hit and time-out-on clears win
   // ****************************************
   logic ready_set, ready_clr;
   always_comb begin
      ready_set = 1'b0;
      if (cmd_a_on || cmd_b_on || (!tmo_on && (rd_start || (rd_stop && !timer_mode)))) begin
         ready_set = 1'b0; // counter update is preempted this cycle
      end else if (tmo_on) begin
         ready_set = expire && !rx_hit;
      end else if (ct_tick && state_ff == CT_RUN) begin
         if (timer_mode) begin
            ready_set = cnt_ff <= 16'h0001 && ct_out_ff;
         end else begin
            ready_set = cnt_ff == 16'h0000 && !done_ff;
         end
      end
      ready_clr = (rd_stop && !tmo_on) || rx_hit || cmd_a_on || cmd_b_on;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ready_ff <= 1'b0;
      end else if (ready_set) begin
         ready_ff <= 1'b1;
      end else if (ready_clr) begin
         ready_ff <= 1'b0;
      end
   end

   // ****************************************
   // input port and change register
   // ****************************************
   ctg_chg_det u_chg (
      .clk(clk),
      .reset(reset),
      .sample_tick(sample_tick),
      .pins(in_pins[3:0]),
      .level(chg_level),
      .change(chg_pulse)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         in_delta_ff <= 4'h0;
      end else begin
         in_delta_ff <= (rd_ips ? 4'h0 : in_delta_ff) | chg_pulse;
      end
   end

   // ****************************************
   // status, interrupt, read mux
   // ****************************************
   always_comb begin
      isr_val = isr_other;
      isr_val[ISR_CT_READY_BIT] = ready_ff;
      isr_val[ISR_IN_CHANGE_BIT] = |(in_delta_ff & acr_ff[3:0]);
   end
   assign intr_n = !(|(isr_val & imr_ff));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata <= RESET_BYTE;
      end else if (rd_stb) begin
         unique case (addr)
            RD_IN_CHANGE: rdata <= {in_delta_ff, chg_level};
            RD_INT_STATUS: rdata <= isr_val;
            RD_COUNT_UPPER: rdata <= cnt_ff[15:8];
            RD_COUNT_LOWER: rdata <= cnt_ff[7:0];
            RD_IN_PINS: rdata <= {1'b1, in_pins[6] & !alt_bus_mode, in_pins[5:0]};
            default: rdata <= RESET_BYTE;
         endcase
      end
   end

   assign clk_sel_a = csr_a_ff;
   assign clk_sel_b = csr_b_ff;
   assign x16_mode = {csr_b_ff[3:0] == CSR_SEL_CT, csr_b_ff[7:4] == CSR_SEL_CT,
                      csr_a_ff[3:0] == CSR_SEL_CT, csr_a_ff[7:4] == CSR_SEL_CT};

   // ****************************************
   // checks
   // ****************************************
   property p_count_zero;
      @(posedge clk) disable iff (reset)
      !tmo_on && !timer_mode && !rd_start && !rd_stop && ct_tick && state_ff == CT_RUN
         && cnt_ff == 16'h0000 && !done_ff
      |=> ready_ff && !ct_out_ff && cnt_ff == CT_ROLL_VALUE;
   endproperty
   a_count_zero: assert property (p_count_zero) else $error("zero count missed");

   property p_roll_quiet;
      @(posedge clk) disable iff (reset)
      !tmo_on && !timer_mode && done_ff && !rd_start ##1 !tmo_on && done_ff && !rd_start
      |-> !ct_out_ff;
   endproperty
   a_roll_quiet: assert property (p_roll_quiet) else $error("output moved after roll");

   property p_tmo_restart;
      @(posedge clk) disable iff (reset)
      tmo_on && rx_hit && !cmd_a_on && !cmd_b_on && state_ff != CT_RESTART
      |=> state_ff == CT_RELOAD && !ready_ff;
   endproperty
   a_tmo_restart: assert property (p_tmo_restart) else $error("character did not restart");

   property p_tmo_on_cmd;
      @(posedge clk) disable iff (reset)
      cmd_a_on |=> state_ff == CT_IDLE && !ready_ff && tmo_a_ff;
   endproperty
   a_tmo_on_cmd: assert property (p_tmo_on_cmd) else $error("time-out on misbehaved");

   property p_ignore_start;
      @(posedge clk) disable iff (reset)
      tmo_on && state_ff == CT_IDLE && rd_start && !rx_hit |=> state_ff == CT_IDLE;
   endproperty
   a_ignore_start: assert property (p_ignore_start) else $error("start honoured");

   property p_reload;
      @(posedge clk) disable iff (reset)
      tmo_on && state_ff == CT_RELOAD && ct_tick && !rx_hit && !cmd_a_on && !cmd_b_on
      |=> state_ff == CT_RESTART && cnt_ff == $past({div_hi_ff, div_lo_ff});
   endproperty
   a_reload: assert property (p_reload) else $error("reload wrong");

   property p_expire_int;
      @(posedge clk) disable iff (reset)
      expire && tmo_on && !rx_hit && imr_ff[ISR_CT_READY_BIT] && !wr_stb |=> !intr_n;
   endproperty
   a_expire_int: assert property (p_expire_int) else $error("no interrupt on expiry");

   property p_pin_read;
      @(posedge clk) disable iff (reset)
      rd_stb && addr == RD_IN_PINS |=> rdata[7] && rdata[5:0] == $past(in_pins[5:0]);
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("input port read wrong");

   property p_set_bits;
      @(posedge clk) disable iff (reset)
      wr_stb && addr == WR_OUT_SET |=> latch_ff == ($past(latch_ff) | $past(wdata));
   endproperty
   a_set_bits: assert property (p_set_bits) else $error("set bits wrong");

   property p_clr_bits;
      @(posedge clk) disable iff (reset)
      wr_stb && addr == WR_OUT_CLR |=> latch_ff == ($past(latch_ff) & ~$past(wdata));
   endproperty
   a_clr_bits: assert property (p_clr_bits) else $error("clear bits wrong");

   property p_delta_clear;
      @(posedge clk) disable iff (reset)
      rd_ips && chg_pulse == 4'h0 |=> in_delta_ff == 4'h0;
   endproperty
   a_delta_clear: assert property (p_delta_clear) else $error("change bits kept");

   c_count_expire: cover property (@(posedge clk) disable iff (reset) ready_set && !tmo_on);
   c_tmo_expire: cover property (@(posedge clk) disable iff (reset) expire && tmo_on);
   c_tmo_withdraw: cover property (@(posedge clk) disable iff (reset)
      ready_ff && rx_hit ##1 !ready_ff);
   c_in_change: cover property (@(posedge clk) disable iff (reset) |chg_pulse);
endmodule

// >>> dv/ctg_host_model.sv
module ctg_host_model (
   input wire logic clk, // system clock
   output logic [3:0] addr, // register address
   output logic [7:0] wdata, // write data
   output logic wr_stb, // write strobe
   output logic rd_stb, // read strobe
   input wire logic [7:0] rdata // read data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr = 4'h0;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end
   // ****************************************
   // bus cycles, one request per call
   // ****************************************
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      // step past the edge so callers see the written state
      #1;
   endtask
   // count is only read back in counter mode, never in timer mode
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(posedge clk);
      #1 v = rdata;
   endtask
   // divider takes integers only, so round to nearest
   function automatic logic [15:0] divisor(input int fin, input int baud);
      return 16'((2 * fin + 32 * baud) / (64 * baud));
   endfunction
endmodule

// >>> dv/tb.sv
`define CHK(got, exp) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      n_fail++; \
      $display("Error at %0t: got 0x%0h expected 0x%0h", $time, got, exp); \
   end \
end

module tb
   import ctg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, alt_bus_mode, ext_ct_tick, rx_load_a, rx_load_b;
   logic wr_stb, rd_stb, ct_out, intr_n;
   logic [3:0] addr, x16_mode;
   logic [6:0] in_pins;
   logic [7:0] wdata, rdata, isr_other, out_pins, clk_sel_a, clk_sel_b, d, l1;
   logic [1:0] op01_src;
   logic [7:2] op_alt_src;
   logic [15:0] div_n;
   int n_fail = 0;
   int cmp_count = 0;
   ctg_host_model i_host (.clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata));
   ctg_top #(.SAMPLE_CYCLES(8)) i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .alt_bus_mode(alt_bus_mode),
      .in_pins(in_pins), .ext_ct_tick(ext_ct_tick), .rx_load_a(rx_load_a),
      .rx_load_b(rx_load_b), .isr_other(isr_other), .op01_src(op01_src),
      .op_alt_src(op_alt_src), .out_pins(out_pins), .ct_out(ct_out), .clk_sel_a(clk_sel_a),
      .clk_sel_b(clk_sel_b), .x16_mode(x16_mode), .intr_n(intr_n));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ****************************************
   // helpers
   // ****************************************
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // window checks both a too-early and a too-late expiry
   task automatic wait_intr(input int lo, input int hi);
      int i;
      i = 0;
      while (intr_n !== 1'b0 && i < hi) begin
         @(posedge clk);
         #1;
         i++;
      end
      if (i >= hi) begin
         n_fail++;
         $display("Error at %0t: got 0x%0h expected 0x0", $time, intr_n);
         report_and_stop();
      end
      `CHK(i >= lo, 1'b1)
   endtask
   task automatic rx(input logic chan_b);
      @(posedge clk);
      if (chan_b) begin
         rx_load_b <= 1'b1;
      end else begin
         rx_load_a <= 1'b1;
      end
      @(posedge clk);
      rx_load_a <= 1'b0;
      rx_load_b <= 1'b0;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      reset = 1'b1;
      {alt_bus_mode, ext_ct_tick, rx_load_a, rx_load_b} = 4'h0;
      // inputs idle high, as with their pull-ups
      in_pins = 7'h7F;
      isr_other = 8'h00;
      op01_src = 2'h2;
      op_alt_src = 6'h20;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1;
      `CHK({ct_out, intr_n, out_pins}, 10'h3FE)
      i_host.rd(4'h3, d);
      `CHK(d, 8'h00)
      i_host.rd(RD_INT_STATUS, d);
      `CHK(d, 8'h00)
      $display("test reset done");
      i_host.wr(WR_OUT_SET, 8'h24);
      `CHK(out_pins, 8'hDA)
      i_host.wr(WR_OUT_CLR, 8'h04);
      `CHK(out_pins, 8'hDE)
      @(posedge clk);
      op_alt_src <= 6'h00;
      i_host.wr(WR_OUT_CFG, 8'h80);
      `CHK(out_pins, 8'h5E)
      i_host.wr(WR_CLK_SEL_A, 8'hD0);
      i_host.wr(WR_CLK_SEL_B, 8'h0D);
      `CHK({clk_sel_a, clk_sel_b, x16_mode}, 20'hD00D9)
      $display("test outputs done");
      @(posedge clk);
      in_pins <= 7'h7E;
      repeat (40) @(posedge clk);
      i_host.rd(RD_IN_CHANGE, d);
      `CHK(d, 8'h1E)
      i_host.rd(RD_IN_CHANGE, d);
      `CHK(d, 8'h0E)
      in_pins <= 7'h7C;
      repeat (3) @(posedge clk);
      in_pins <= 7'h7E;
      repeat (40) @(posedge clk);
      i_host.rd(RD_IN_CHANGE, d);
      `CHK(d, 8'h0E)
      in_pins <= 7'h55;
      i_host.rd(RD_IN_PINS, d);
      `CHK(d, 8'hD5)
      alt_bus_mode <= 1'b1;
      i_host.rd(RD_IN_PINS, d);
      `CHK(d, 8'h95)
      $display("test inputs done");
      i_host.wr(WR_INT_MASK, 8'h08);
      i_host.wr(WR_AUX_CTRL, 8'h10);
      i_host.wr(WR_DIV_UPPER, 8'h00);
      i_host.wr(WR_DIV_LOWER, 8'h03);
      i_host.rd(RD_START_CMD, d);
      wait_intr(36, 80);
      `CHK(ct_out, 1'b0)
      i_host.rd(RD_INT_STATUS, d);
      `CHK(d, 8'h08)
      i_host.rd(RD_COUNT_UPPER, d);
      `CHK(d, 8'hFF)
      i_host.rd(RD_COUNT_LOWER, l1);
      repeat (40) @(posedge clk);
      i_host.rd(RD_COUNT_LOWER, d);
      `CHK(d !== l1, 1'b1)
      i_host.rd(RD_STOP_CMD, d);
      #1;
      `CHK(intr_n, 1'b1)
      $display("test counter done");
      div_n = i_host.divisor(12_500_000, 97_656);
      i_host.wr(WR_DIV_LOWER, div_n[7:0]);
      i_host.wr(WR_CMD_A, {CMD_TMO_ON, 4'h0});
      rx(1'b0);
      wait_intr(64, 160);
      i_host.rd(RD_START_CMD, d);
      i_host.rd(RD_STOP_CMD, d);
      i_host.rd(RD_INT_STATUS, d);
      `CHK(d, 8'h08)
      rx(1'b0);
      repeat (2) @(posedge clk);
      `CHK(intr_n, 1'b1)
      i_host.rd(RD_INT_STATUS, d);
      `CHK(d, 8'h00)
      wait_intr(60, 160);
      i_host.wr(WR_CMD_A, {CMD_TMO_ON, 4'h0});
      repeat (200) @(posedge clk);
      `CHK(intr_n, 1'b1)
      i_host.wr(WR_CMD_B, {CMD_TMO_ON, 4'h0});
      rx(1'b0);
      repeat (60) @(posedge clk);
      rx(1'b1);
      wait_intr(64, 160);
      i_host.wr(WR_CMD_A, {CMD_TMO_OFF, 4'h0});
      i_host.wr(WR_CMD_B, {CMD_TMO_OFF, 4'h0});
      i_host.rd(RD_STOP_CMD, d);
      i_host.rd(RD_INT_STATUS, d);
      `CHK(d, 8'h00)
      $display("test time-out done");
      report_and_stop();
   end
endmodule
